// *** gpbc_board.sv ***
// board-side model of the port B and port C pins
module gpbc_board (
  input  wire logic [7:0] drive,
  input  wire logic [7:0] oe,
  input  wire logic [7:0] out,
  output logic      [7:0] pin
);
  // a driven pin shows the device level, an undriven one the board level
  assign pin = (oe & out) | (~oe & drive);
endmodule

// *** gpbc_pkg.sv ***
// shared constants for the port B / port C general-purpose I/O block
package gpbc_pkg;

  // ****************************************************************
  // widths
  // ****************************************************************
  localparam int unsigned PORT_W    = 8;
  localparam int unsigned ADDR_W    = 8;
  localparam int unsigned I2C_CHANS = 3;

  // ****************************************************************
  // register byte offsets
  // ****************************************************************
  localparam logic [7:0] OFS_PB_PIN = 8'h00;  // read pins, write shared direction
  localparam logic [7:0] OFS_PB_DIR = 8'h04;
  localparam logic [7:0] OFS_PB_OUT = 8'h08;
  localparam logic [7:0] OFS_PC_PIN = 8'h0c;  // read pins, write port C direction
  localparam logic [7:0] OFS_PC_OUT = 8'h10;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [7:0] RST_DIR    = 8'h00;
  localparam logic [7:0] RST_OUT    = 8'h00;
  localparam logic [7:0] RST_SHARED = 8'h00;
  localparam logic [7:0] RST_SYNC   = 8'h00;

  // ****************************************************************
  // bus encodings
  // ****************************************************************
  localparam logic        HRESP_OKAY = 1'b0;
  localparam logic [23:0] RD_PAD     = 24'h000000;

  typedef enum logic [0:0] {
    PH_IDLE  = 1'b0,
    PH_WRITE = 1'b1
  } gpbc_phase_t;

endpackage

// *** gpbc_ports.sv ***
// port B and port C general-purpose I/O with AHB-Lite register access
//
// Added by the designer: the AHB-Lite register port and the placing of the registers.

// How it works
// - port B pin levels readable, read-only
// - port B pin address writes shared direction
// - pin level reads follow pins after reset
// - port B direction 1 drives output latch
// - port B input n feeds event n+8
// - port C direction: 1 output, resets 0
// - port C direction address reads pins
// - port C output latch read/write, resets 0
// - port B direction: 1 output, resets 0
// - port B output latch read/write, resets 0
// - port C pin read, write sets direction
// - enabled I2C channel k owns port C pins 2k and 2k+1
module gpbc_ports (
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic        ce,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  input  wire logic [7:0]  pbPinIn,
  output logic      [7:0]  pbPinOut,
  output logic      [7:0]  pbPinOe,
  input  wire logic [7:0]  eventCountEnable,
  output logic      [7:0]  eventInput,
  input  wire logic [7:0]  pcPinIn,
  output logic      [7:0]  pcPinOut,
  output logic      [7:0]  pcPinOe,
  input  wire logic [2:0]  i2cChannelEnable,
  input  wire logic [5:0]  i2cLineOut,
  input  wire logic [5:0]  i2cLineOe,
  output logic      [5:0]  i2cLineIn,
  output logic      [7:0]  sharedDirection
);

  // ****************************************************************
  // reset release
  // ****************************************************************
  logic [1:0] rstSync_q;
  logic       rstN;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rstSync_q <= 2'h0;
    end else begin
      rstSync_q <= {rstSync_q[0], 1'b1};
    end
  end

  assign rstN = rstSync_q[1];

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [7:0] pbLevel;
  logic [7:0] pcLevel;

  gpbc_sync #(.W(gpbc_pkg::PORT_W)) uPbSync (
    .mclk (mclk),
    .rstN (rstN),
    .ce   (ce),
    .d    (pbPinIn),
    .q    (pbLevel)
  );

  gpbc_sync #(.W(gpbc_pkg::PORT_W)) uPcSync (
    .mclk (mclk),
    .rstN (rstN),
    .ce   (ce),
    .d    (pcPinIn),
    .q    (pcLevel)
  );

  // ****************************************************************
  // AHB-Lite slave
  // ****************************************************************
  // zero wait states; a low clock enable stalls the bus instead of losing beats
  logic                  addrTake;
  logic                  commit;
  gpbc_pkg::gpbc_phase_t phase_q;
  logic [7:0]            dAddr_q;
  logic [7:0]            wrByte;
  logic [7:0]            aAddr;

  assign hreadyout = ce;
  assign hresp     = gpbc_pkg::HRESP_OKAY;
  assign addrTake  = ce && hready && hsel && htrans[1];
  assign commit    = ce && hready && (phase_q == gpbc_pkg::PH_WRITE);
  assign wrByte    = hwdata[7:0];
  assign aAddr     = haddr[7:0];

  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      phase_q <= gpbc_pkg::PH_IDLE;
      dAddr_q <= 8'h00;
    end else if (ce && hready) begin
      phase_q <= (addrTake && hwrite) ? gpbc_pkg::PH_WRITE : gpbc_pkg::PH_IDLE;
      dAddr_q <= aAddr;
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  logic [7:0] pbDir_q;
  logic [7:0] pbOut_q;
  logic [7:0] pcDir_q;
  logic [7:0] pcOut_q;
  logic [7:0] shared_q;

  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      shared_q <= gpbc_pkg::RST_SHARED;
    end else if (commit && dAddr_q == gpbc_pkg::OFS_PB_PIN) begin
      shared_q <= wrByte;
    end
  end

  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      pbDir_q <= gpbc_pkg::RST_DIR;
    end else if (commit && dAddr_q == gpbc_pkg::OFS_PB_DIR) begin
      pbDir_q <= wrByte;
    end
  end

  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      pbOut_q <= gpbc_pkg::RST_OUT;
    end else if (commit && dAddr_q == gpbc_pkg::OFS_PB_OUT) begin
      pbOut_q <= wrByte;
    end
  end

  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      pcDir_q <= gpbc_pkg::RST_DIR;
    end else if (commit && dAddr_q == gpbc_pkg::OFS_PC_PIN) begin
      pcDir_q <= wrByte;
    end
  end

  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      pcOut_q <= gpbc_pkg::RST_OUT;
    end else if (commit && dAddr_q == gpbc_pkg::OFS_PC_OUT) begin
      pcOut_q <= wrByte;
    end
  end

  assign sharedDirection = shared_q;

  // ****************************************************************
  // read data
  // ****************************************************************
  // a read right behind a write to the same latch sees the new value
  logic       fwd;
  logic [7:0] rdByte;

  assign fwd = commit && (dAddr_q == aAddr);

  always_comb begin
    case (aAddr)
      gpbc_pkg::OFS_PB_PIN: rdByte = pbLevel;
      gpbc_pkg::OFS_PB_OUT: rdByte = fwd ? wrByte : pbOut_q;
      gpbc_pkg::OFS_PC_PIN: rdByte = pcLevel;
      gpbc_pkg::OFS_PC_OUT: rdByte = fwd ? wrByte : pcOut_q;
      default:              rdByte = 8'h00;                       // direction is write-only
    endcase
  end

  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      hrdata <= 32'h00000000;
    end else if (addrTake && !hwrite) begin
      hrdata <= {gpbc_pkg::RD_PAD, rdByte};
    end
  end

  // ****************************************************************
  // pin drive
  // ****************************************************************
  assign pbPinOe  = pbDir_q;
  assign pbPinOut = pbOut_q;
  // counter sees nothing from a pin software left as output
  assign eventInput = eventCountEnable & ~pbDir_q & pbLevel;

  logic [5:0] i2cOwn;

  for (genvar k = 0; k < gpbc_pkg::I2C_CHANS; k++) begin : gChan
    assign i2cOwn[2*k]   = i2cChannelEnable[k];
    assign i2cOwn[2*k+1] = i2cChannelEnable[k];
  end

  // I2C lines override direction while their channel is on
  assign pcPinOe  = {pcDir_q[7:6], (i2cOwn & i2cLineOe) | (~i2cOwn & pcDir_q[5:0])};
  assign pcPinOut = {pcOut_q[7:6], (i2cOwn & i2cLineOut) | (~i2cOwn & pcOut_q[5:0])};
  assign i2cLineIn = pcLevel[5:0];

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstN);

  a_pb_pin_read: assert property (
    addrTake && !hwrite && aAddr == gpbc_pkg::OFS_PB_PIN
      |=> hrdata == {gpbc_pkg::RD_PAD, $past(pbLevel)})
    else $error("port B pin read mismatch");

  a_shared_write: assert property (
    commit && dAddr_q == gpbc_pkg::OFS_PB_PIN
      |=> sharedDirection == $past(wrByte) && $stable(pbDir_q))
    else $error("shared direction write wrong");

  // synchroniser must have left reset before the sampled pin edge
  a_pb_level_track: assert property (
    ce [*3] ##0 $past(rstN, 2)
      |-> pbLevel == $past(pbPinIn, 2))
    else $error("port B level not following pins");

  a_pb_dir_drive: assert property (
    commit && dAddr_q == gpbc_pkg::OFS_PB_DIR
      |=> pbPinOe == $past(wrByte))
    else $error("port B direction not applied");

  a_pb_out_drive: assert property (
    commit && dAddr_q == gpbc_pkg::OFS_PB_OUT
      |=> pbPinOut == $past(wrByte))
    else $error("port B output not applied");

  a_event_map: assert property (
    eventCountEnable[0] && !pbPinOe[0] && ce [*3] ##0 $past(rstN, 2)
      |-> eventInput[0] == $past(pbPinIn[0], 2))
    else $error("event input 8 not following pin 0");

  a_pc_dir_write: assert property (
    commit && dAddr_q == gpbc_pkg::OFS_PC_PIN ##1 i2cChannelEnable == 3'h0
      |-> pcPinOe == $past(wrByte))
    else $error("port C direction not applied");

  a_pc_pin_read: assert property (
    addrTake && !hwrite && aAddr == gpbc_pkg::OFS_PC_PIN
      |=> hrdata[7:0] == $past(pcLevel))
    else $error("port C pin read mismatch");

  a_pc_out_rw: assert property (
    commit && dAddr_q == gpbc_pkg::OFS_PC_OUT ##1
      (addrTake && !hwrite && aAddr == gpbc_pkg::OFS_PC_OUT)
      |=> hrdata[7:0] == $past(wrByte, 2))
    else $error("port C latch readback wrong");

  a_pb_out_rw: assert property (
    commit && dAddr_q == gpbc_pkg::OFS_PB_OUT ##1
      (addrTake && !hwrite && aAddr == gpbc_pkg::OFS_PB_OUT)
      |=> hrdata[7:0] == $past(wrByte, 2))
    else $error("port B latch readback wrong");

  a_dir_write_only: assert property (
    addrTake && !hwrite && aAddr == gpbc_pkg::OFS_PB_DIR |=> hrdata == 32'h00000000)
    else $error("direction register readable");

  a_i2c_override: assert property (
    i2cChannelEnable[1] |-> pcPinOe[3:2] == i2cLineOe[3:2] && pcPinOut[3:2] == i2cLineOut[3:2])
    else $error("I2C channel not owning its pins");

  a_reset_clear: assert property (
    $rose(rstN) |-> pbPinOe == 8'h00 && pbPinOut == 8'h00 && pcOut_q == 8'h00)
    else $error("registers not cleared by reset");

  a_event_masked: assert property (
    (eventInput & pbPinOe) == 8'h00)
    else $error("event input active on an output pin");

  a_pc_high_plain: assert property (
    pcPinOut[7:6] == pcOut_q[7:6] && pcPinOe[7:6] == pcDir_q[7:6])
    else $error("port C upper pins not plain I/O");

  a_i2c_line_in: assert property (
    ce [*3] ##0 $past(rstN, 2)
      |-> i2cLineIn == $past(pcPinIn[5:0], 2))
    else $error("I2C line input not following pins");

  a_rdata_hold: assert property (
    !(addrTake && !hwrite) |=> $stable(hrdata))
    else $error("read data changed without a read");

  // a stalled clock enable must not lose or invent register updates
  a_ce_freeze: assert property (
    !ce |=> $stable(pbDir_q) && $stable(pbOut_q) && $stable(pcDir_q) && $stable(pcOut_q)
      && $stable(shared_q) && $stable(phase_q) && $stable(pbLevel) && $stable(pcLevel))
    else $error("clock enable low did not freeze state");

endmodule

// *** gpbc_sync.sv ***
// two-flop synchroniser for a group of pin inputs
module gpbc_sync #(
  parameter int unsigned W = 8
) (
  input  wire logic         mclk,
  input  wire logic         rstN,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_q;

  // only the second stage is ever read
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      meta_q <= W'(gpbc_pkg::RST_SYNC);
      q      <= W'(gpbc_pkg::RST_SYNC);
    end else if (ce) begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule

// *** test_eight_bit_ports_b_and_c_io.sv ***
// self-checking bench for the port B / port C block
module test_eight_bit_ports_b_and_c_io;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk, nrst, ce, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize, i2cChannelEnable;
  logic [7:0]  pbPinIn, pbPinOut, pbPinOe, eventCountEnable, eventInput, pbDrv;
  logic [7:0]  pcPinIn, pcPinOut, pcPinOe, sharedDirection, pcDrv, eo, eq;
  logic [5:0]  i2cLineOut, i2cLineOe, i2cLineIn;
  logic [7:0]  pbD, pbL, pcD, pcL, sh;
  int          errCount, cmpCount;

  assign hready = hreadyout;
  gpbc_ports gpbc_ports_i (.mclk, .nrst, .ce, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready, .hreadyout, .hresp, .hrdata, .pbPinIn, .pbPinOut, .pbPinOe,
    .eventCountEnable, .eventInput, .pcPinIn, .pcPinOut, .pcPinOe, .i2cChannelEnable,
    .i2cLineOut, .i2cLineOe, .i2cLineIn, .sharedDirection);
  gpbc_board pb_board_i (.drive(pbDrv), .oe(pbPinOe), .out(pbPinOut), .pin(pbPinIn));
  gpbc_board pc_board_i (.drive(pcDrv), .oe(pcPinOe), .out(pcPinOut), .pin(pcPinIn));

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [7:0] lvl(input logic [7:0] d, o, b);
    return (d & o) | (~d & b);
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      errCount++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // single AHB-Lite transfer; waits on hready, never on a fixed count
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h000000, a};
    hwrite <= wr;
    do @(posedge mclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task automatic w(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] x;
    bus(1'b1, a, {24'h000000, d}, x);
  endtask

  task automatic r(input logic [7:0] a, input logic [7:0] exp);
    logic [31:0] x;
    bus(1'b0, a, 32'h00000000, x);
    chk(x, {24'h000000, exp});
  endtask

  task automatic conclude();
    $display("compares %0d mismatches %0d", cmpCount, errCount);
    if (errCount == 0 && cmpCount > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ****************************************************************
  // clock, watchdog, tests
  // ****************************************************************
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // whole run is well under a thousand cycles
  initial begin
    #200000;
    errCount++;
    conclude();
  end

  initial begin
    nrst = 1'b0; ce = 1'b1; hsel = 1'b0; haddr = '0; htrans = '0; hwrite = 1'b0;
    hsize = 3'h2; hwdata = '0; eventCountEnable = '0; pbDrv = '0; pcDrv = '0;
    i2cChannelEnable = '0; i2cLineOut = '0; i2cLineOe = '0;
    errCount = 0; cmpCount = 0;
    void'($urandom(94085));
    repeat (10) @(posedge mclk);
    nrst <= 1'b1;
    repeat (3) @(posedge mclk);
    chk(pbPinOe, 8'h00);
    chk(pcPinOe, 8'h00);
    chk(hresp, 1'b0);
    r(8'h08, 8'h00);
    r(8'h10, 8'h00);
    r(8'h04, 8'h00);
    r(8'h20, 8'h00);
    $display("test reset values done");
    for (int i = 0; i < 8; i++) begin
      pbD = 8'($urandom); pbL = 8'($urandom); pcD = 8'($urandom);
      pcL = 8'($urandom); sh = 8'($urandom);
      pbDrv <= 8'($urandom);
      pcDrv <= 8'($urandom);
      w(8'h04, pbD);
      eventCountEnable <= 8'($urandom) & ~pbD;
      w(8'h08, pbL);
      r(8'h08, pbL);
      w(8'h0c, pcD);
      w(8'h10, pcL);
      #1 chk(pcPinOut, pcL);
      @(posedge mclk);
      w(8'h00, sh);
      repeat (3) @(posedge mclk);
      chk(pbPinOe, pbD);
      chk(pbPinOut, pbL);
      chk(pcPinOe, pcD);
      chk(sharedDirection, sh);
      chk(eventInput, eventCountEnable & ~pbD & lvl(pbD, pbL, pbDrv));
      r(8'h00, lvl(pbD, pbL, pbDrv));
      r(8'h0c, lvl(pcD, pcL, pcDrv));
      r(8'h08, pbL);
      r(8'h10, pcL);
    end
    $display("test random registers done");
    for (int k = 0; k < 3; k++) begin
      i2cChannelEnable <= 3'(1 << k);
      i2cLineOut <= 6'($urandom);
      i2cLineOe <= 6'($urandom);
      @(posedge mclk);
      #1;
      eo = pcD;
      eq = pcL;
      eo[2*k+:2] = i2cLineOe[2*k+:2];
      eq[2*k+:2] = i2cLineOut[2*k+:2];
      chk(pcPinOe, eo);
      chk(pcPinOut, eq);
      repeat (3) @(posedge mclk);
      chk(i2cLineIn, lvl(eo, eq, pcDrv) & 8'h3f);
    end
    $display("test i2c ownership done");
    ce <= 1'b0;
    @(posedge mclk);
    chk(hreadyout, 1'b0);
    ce <= 1'b1;
    @(posedge mclk);
    w(8'h10, 8'hff);
    r(8'h10, 8'hff);
    chk(pcPinOut & 8'hc0, 8'hc0);
    nrst <= 1'b0;
    @(posedge mclk);
    chk(pcPinOut & 8'hc0, 8'h00);
    chk(pbPinOe, 8'h00);
    chk(sharedDirection, 8'h00);
    nrst <= 1'b1;
    repeat (3) @(posedge mclk);
    r(8'h10, 8'h00);
    $display("test second reset done");
    conclude();
  end
endmodule
